// file: shared/ssp_pkg.sv
// Constants and carrier types for the synthesizer sticky status and port lock bank
package ssp_pkg;
    localparam logic [8:0] SSP_OFS_MON1 = 9'h1b1;
    localparam logic [8:0] SSP_OFS_MON2 = 9'h1b2;
    localparam logic [8:0] SSP_OFS_MON3 = 9'h1b3;
    localparam logic [8:0] SSP_OFS_IRQ = 9'h1b7;
    localparam logic [8:0] SSP_OFS_CTRL = 9'h1fe;
    localparam int SSP_MON_ALIGN_LSB = 4;
    localparam int SSP_MON_UNLOCK_BIT = 2;
    localparam int SSP_CTRL_LOCK_BIT = 7;
    localparam int SSP_CTRL_STAT_BIT = 0;
    localparam logic [7:0] SSP_MON_MASK = 8'hf4;
    localparam logic [7:0] SSP_IRQ_MASK = 8'h0f;
    localparam logic [7:0] SSP_RESET_VAL = 8'h00;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } ssp_req_s;
    typedef struct packed {
        logic ack;
        logic fail;
        logic [7:0] rdata;
    } ssp_rsp_s;
endpackage : ssp_pkg

// file: hdl/ssp_sticky_cell.sv
// One sticky status byte: events set bits, acknowledges clear them, set wins
`timescale 1ns/1ps
module ssp_sticky_cell (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] set_i,
    input wire logic [7:0] clr_i,
    output logic [7:0] q_o
);
    logic [7:0] q_r;
    logic [7:0] q_nxt;

    always_comb begin
        q_nxt = (q_r & ~clr_i) | set_i; // RULE_09
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_r <= ssp_pkg::SSP_RESET_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule : ssp_sticky_cell

// file: hdl/ssp_status_bank.sv
// Register bank: synthesizer sticky monitors, interrupt pending and host port lock
//
// Contract
// RULE_01: Each synthesizer 0..3 interrupt sets its pending bit 0..3, held until acknowledged.
// RULE_02: While lockout is set, writes to every other register are ignored.
// RULE_03: With lockout zero, all registers accept writes normally.
// RULE_04: Failed host access sets control bit 0; a successful access clears it.
// RULE_05: Monitor registers 1..3 hold alignment done for dividers D..A in bits 7..4.
// RULE_06: Monitor registers 1..3 hold a sticky unlock flag in bit 2.
// RULE_07: Alignment done flag sets on completion and holds until acknowledged.
// RULE_08: Unlock flag sets on synth_unlock_seen and holds until acknowledged.
// RULE_09: Writing ones clears only those flags; a same-cycle new event stays set.
`timescale 1ns/1ps
module ssp_status_bank (
    input wire logic clk_i,
    input wire logic resetn_i,
    input ssp_pkg::ssp_req_s host_req_i,
    output ssp_pkg::ssp_rsp_s host_rsp_o,
    input wire logic [3:0] align_done_s1_i,
    input wire logic [3:0] align_done_s2_i,
    input wire logic [3:0] align_done_s3_i,
    input wire logic [2:0] synth_unlock_seen_i,
    input wire logic [3:0] synth_irq_i,
    output logic port_locked_o
);
    logic [7:0] mon1_q;
    logic [7:0] mon2_q;
    logic [7:0] mon3_q;
    logic [7:0] irq_q;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    ssp_pkg::ssp_rsp_s rsp_r;
    ssp_pkg::ssp_rsp_s rsp_nxt;
    logic access;
    logic hit;
    logic locked;
    logic wr_ok;
    logic fail;
    logic addr_bad;
    logic wr_blocked;

    // Register selects decoded from the request address
    logic sel_mon1;
    logic sel_mon2;
    logic sel_mon3;
    logic sel_irq;
    logic sel_ctrl;

    // Event sets and acknowledge clears of the sticky cells
    logic [7:0] mon1_set;
    logic [7:0] mon2_set;
    logic [7:0] mon3_set;
    logic [7:0] irq_set;
    logic [7:0] mon1_clr;
    logic [7:0] mon2_clr;
    logic [7:0] mon3_clr;
    logic [7:0] irq_clr;

    // Read data before the response register
    logic [7:0] rdata_nxt;

    // Monitor set vector: alignment done in bits 7..4, unlock in bit 2
    function automatic logic [7:0] mon_set(input logic [3:0] align, input logic unlock);
        logic [7:0] v;
        v = 8'h00;
        v[ssp_pkg::SSP_MON_ALIGN_LSB +: 4] = align; // RULE_05 RULE_07
        v[ssp_pkg::SSP_MON_UNLOCK_BIT] = unlock; // RULE_06 RULE_08
        mon_set = v;
    endfunction : mon_set

    // Acknowledge mask: written ones clear only the implemented flags
    function automatic logic [7:0] ack_bits(input logic ok, input logic [7:0] d, input logic [7:0] mask);
        ack_bits = ok ? (d & mask) : 8'h00; // RULE_09
    endfunction : ack_bits

    // One select per mapped register; an unmapped address selects none
    always_comb begin
        sel_mon1 = 1'h0;
        sel_mon2 = 1'h0;
        sel_mon3 = 1'h0;
        sel_irq = 1'h0;
        sel_ctrl = 1'h0;
        case (host_req_i.addr)
            ssp_pkg::SSP_OFS_MON1: begin
                sel_mon1 = 1'h1;
            end
            ssp_pkg::SSP_OFS_MON2: begin
                sel_mon2 = 1'h1;
            end
            ssp_pkg::SSP_OFS_MON3: begin
                sel_mon3 = 1'h1;
            end
            ssp_pkg::SSP_OFS_IRQ: begin
                sel_irq = 1'h1;
            end
            ssp_pkg::SSP_OFS_CTRL: begin
                sel_ctrl = 1'h1;
            end
            default: begin
                sel_ctrl = 1'h0;
            end
        endcase
    end

    // Access outcome: unmapped address or write refused under lockout
    assign access = host_req_i.wr | host_req_i.rd;
    assign hit = sel_mon1 | sel_mon2 | sel_mon3 | sel_irq | sel_ctrl;
    assign locked = ctrl_r[ssp_pkg::SSP_CTRL_LOCK_BIT];
    assign addr_bad = access && !hit; // RULE_04
    // Lock register itself stays writable so software can unlock
    assign wr_blocked = host_req_i.wr && hit && locked && !sel_ctrl; // RULE_02
    assign wr_ok = host_req_i.wr && hit && !wr_blocked; // RULE_02 RULE_03
    assign fail = addr_bad || wr_blocked; // RULE_04

    // Event sets and acknowledge clears of the sticky registers
    always_comb begin
        mon1_set = mon_set(align_done_s1_i, synth_unlock_seen_i[0]);
        mon2_set = mon_set(align_done_s2_i, synth_unlock_seen_i[1]);
        mon3_set = mon_set(align_done_s3_i, synth_unlock_seen_i[2]);
        irq_set = {4'h0, synth_irq_i}; // RULE_01
        mon1_clr = ack_bits(wr_ok && sel_mon1, host_req_i.wdata, ssp_pkg::SSP_MON_MASK); // RULE_09
        mon2_clr = ack_bits(wr_ok && sel_mon2, host_req_i.wdata, ssp_pkg::SSP_MON_MASK); // RULE_09
        mon3_clr = ack_bits(wr_ok && sel_mon3, host_req_i.wdata, ssp_pkg::SSP_MON_MASK); // RULE_09
        irq_clr = ack_bits(wr_ok && sel_irq, host_req_i.wdata, ssp_pkg::SSP_IRQ_MASK); // RULE_09
    end

    // Sticky registers: three monitors and the interrupt pending byte
    ssp_sticky_cell u_mon1 (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(mon1_set),
        .clr_i(mon1_clr),
        .q_o(mon1_q)
    );

    ssp_sticky_cell u_mon2 (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(mon2_set),
        .clr_i(mon2_clr),
        .q_o(mon2_q)
    );

    ssp_sticky_cell u_mon3 (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(mon3_set),
        .clr_i(mon3_clr),
        .q_o(mon3_q)
    );

    ssp_sticky_cell u_irq (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(irq_set), // RULE_01
        .clr_i(irq_clr), // RULE_09
        .q_o(irq_q)
    );

    always_comb begin
        ctrl_nxt = ctrl_r;
        // Lockout follows the written bit; the written status bit is ignored
        if (wr_ok && sel_ctrl) begin
            ctrl_nxt[ssp_pkg::SSP_CTRL_LOCK_BIT] = host_req_i.wdata[ssp_pkg::SSP_CTRL_LOCK_BIT]; // RULE_02 RULE_03
        end
        // Status records the outcome of the latest access
        if (access) begin
            ctrl_nxt[ssp_pkg::SSP_CTRL_STAT_BIT] = fail; // RULE_04
        end
    end

    // Read mux: reserved bits read as zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (host_req_i.rd) begin
            case (host_req_i.addr)
                ssp_pkg::SSP_OFS_MON1: begin
                    rdata_nxt = mon1_q & ssp_pkg::SSP_MON_MASK; // RULE_05
                end
                ssp_pkg::SSP_OFS_MON2: begin
                    rdata_nxt = mon2_q & ssp_pkg::SSP_MON_MASK; // RULE_05
                end
                ssp_pkg::SSP_OFS_MON3: begin
                    rdata_nxt = mon3_q & ssp_pkg::SSP_MON_MASK; // RULE_05
                end
                ssp_pkg::SSP_OFS_IRQ: begin
                    rdata_nxt = irq_q & ssp_pkg::SSP_IRQ_MASK; // RULE_01
                end
                ssp_pkg::SSP_OFS_CTRL: begin
                    rdata_nxt = ctrl_r;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // Every access is answered one cycle later; fail marks a refusal
    always_comb begin
        rsp_nxt.ack = access;
        rsp_nxt.fail = fail; // RULE_04
        rsp_nxt.rdata = rdata_nxt;
    end

    // Control register: lockout bit and access status
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= ssp_pkg::SSP_RESET_VAL;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Response register: one-cycle acknowledge with its data
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    assign host_rsp_o = rsp_r;
    assign port_locked_o = locked;
endmodule : ssp_status_bank

// file: bench/ssp_checker.sv
// Assertion checker for the sticky status bank
`timescale 1ns/1ps
module ssp_checker (
    input wire logic clk_i,
    input wire logic resetn_i,
    input ssp_pkg::ssp_req_s host_req_i,
    input ssp_pkg::ssp_rsp_s host_rsp_o,
    input wire logic [3:0] align_done_s1_i,
    input wire logic [2:0] synth_unlock_seen_i,
    input wire logic [3:0] synth_irq_i,
    input wire logic port_locked_o
);
    wire [8:0] ad = host_req_i.addr;
    wire rd = host_req_i.rd & ~host_req_i.wr;
    wire wr = host_req_i.wr & ~host_req_i.rd;
    wire ak = host_rsp_o.ack;
    wire fl = host_rsp_o.fail;
    wire [7:0] q = host_rsp_o.rdata;
    wire mp = ad inside {9'h1b1, 9'h1b2, 9'h1b3, 9'h1b7, 9'h1fe};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_ack; rd || wr |=> ak; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_unm; (rd || wr) && !mp |=> fl && q == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped");
    property p_irq; synth_irq_i[0] ##1 (rd && ad == 9'h1b7) |=> q[0]; endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_lck; port_locked_o && wr && ad != 9'h1fe |=> fl; endproperty
    a_lck: assert property (p_lck) else $error("lock");
    property p_opn; !port_locked_o && wr && mp |=> !fl; endproperty
    a_opn: assert property (p_opn) else $error("open");
    property p_lol; synth_unlock_seen_i[0] ##1 (rd && ad == 9'h1b1) |=> q[2]; endproperty
    a_lol: assert property (p_lol) else $error("unlock");
    property p_aln; align_done_s1_i[3] ##1 (rd && ad == 9'h1b1) |=> q[7]; endproperty
    a_aln: assert property (p_aln) else $error("align");
    property p_wlk; wr && ad == 9'h1fe |=> port_locked_o == $past(host_req_i.wdata[7]); endproperty
    a_wlk: assert property (p_wlk) else $error("lockout");
endmodule : ssp_checker
bind ssp_status_bank ssp_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .host_req_i(host_req_i),
    .host_rsp_o(host_rsp_o), .align_done_s1_i(align_done_s1_i), .synth_unlock_seen_i(synth_unlock_seen_i),
    .synth_irq_i(synth_irq_i), .port_locked_o(port_locked_o));

// file: bench/tb_top.sv
// Self-checking testbench for the sticky status bank
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'h0;
    logic resetn_i = 1'h0;
    ssp_pkg::ssp_req_s rq = '0;
    ssp_pkg::ssp_rsp_s rs;
    logic [3:0] a1 = 4'h0, a2 = 4'h0, a3 = 4'h0, iq = 4'h0;
    logic [2:0] ul = 3'h0;
    logic lk;
    int n_errors = 0;
    int tests_run = 0;
    ssp_status_bank dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .host_req_i(rq), .host_rsp_o(rs),
        .align_done_s1_i(a1), .align_done_s2_i(a2), .align_done_s3_i(a3), .synth_unlock_seen_i(ul),
        .synth_irq_i(iq), .port_locked_o(lk));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task acc(input logic w, input logic [8:0] a, input logic [7:0] d, input logic [7:0] e, input logic f);
        rq = '{w, !w, a, d};
        @(negedge clk_i);
        rq = '0;
        chk("ack", 8'(rs.ack), 8'h01);
        chk("fail", 8'(rs.fail), 8'(f));
        chk("rdata", rs.rdata, e);
        @(negedge clk_i);
        chk("ack_idle", 8'(rs.ack), 8'h00);
    endtask : acc
    task t_reset;
        for (int i = 0; i < 7; i++) begin
            acc(1'h0, 9'h1b1 + 9'(i), 8'h00, 8'h00, 1'(i > 2 && i < 6));
        end
        acc(1'h0, 9'h1fe, 8'h00, 8'h00, 1'h0);
    endtask : t_reset
    task t_mon;
        {a1, a2, a3, ul} = {4'h9, 4'h6, 4'h3, 3'h7};
        @(negedge clk_i);
        {a1, a2, a3, ul} = '0;
        acc(1'h0, 9'h1b1, 8'h00, 8'h94, 1'h0);
        acc(1'h0, 9'h1b2, 8'h00, 8'h64, 1'h0);
        acc(1'h0, 9'h1b3, 8'h00, 8'h34, 1'h0);
        a1 = 4'h8;
        acc(1'h1, 9'h1b1, 8'h94, 8'h00, 1'h0);
        a1 = 4'h0;
        acc(1'h0, 9'h1b1, 8'h00, 8'h80, 1'h0);
        acc(1'h1, 9'h1b2, 8'h40, 8'h00, 1'h0);
        acc(1'h0, 9'h1b2, 8'h00, 8'h24, 1'h0);
    endtask : t_mon
    task t_irq;
        iq = 4'hf;
        @(negedge clk_i);
        iq = 4'h0;
        acc(1'h0, 9'h1b7, 8'h00, 8'h0f, 1'h0);
        acc(1'h1, 9'h1b7, 8'h05, 8'h00, 1'h0);
        acc(1'h0, 9'h1b7, 8'h00, 8'h0a, 1'h0);
    endtask : t_irq
    task t_lock;
        acc(1'h1, 9'h1fe, 8'h81, 8'h00, 1'h0);
        chk("lock", 8'(lk), 8'h01);
        acc(1'h0, 9'h1fe, 8'h00, 8'h80, 1'h0);
        acc(1'h1, 9'h1b7, 8'h0a, 8'h00, 1'h1);
        acc(1'h0, 9'h1fe, 8'h00, 8'h81, 1'h0);
        acc(1'h0, 9'h1b7, 8'h00, 8'h0a, 1'h0);
        acc(1'h1, 9'h1fe, 8'h00, 8'h00, 1'h0);
        chk("unlock", 8'(lk), 8'h00);
        acc(1'h1, 9'h1b7, 8'h0a, 8'h00, 1'h0);
        acc(1'h0, 9'h1b7, 8'h00, 8'h00, 1'h0);
    endtask : t_lock
    task t_rst2;
        iq = 4'h3;
        acc(1'h1, 9'h1fe, 8'h80, 8'h00, 1'h0);
        iq = 4'h0;
        chk("lock", 8'(lk), 8'h01);
        acc(1'h0, 9'h1b7, 8'h00, 8'h03, 1'h0);
        resetn_i = 1'h0;
        @(negedge clk_i);
        chk("rst_lock", 8'(lk), 8'h00);
        chk("rst_ack", 8'(rs.ack), 8'h00);
        @(negedge clk_i);
        resetn_i = 1'h1;
        acc(1'h0, 9'h1b7, 8'h00, 8'h00, 1'h0);
        acc(1'h0, 9'h1fe, 8'h00, 8'h00, 1'h0);
    endtask : t_rst2
    task end_of_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(negedge clk_i);
        resetn_i = 1'h1;
        t_reset;
        t_mon;
        t_irq;
        t_lock;
        t_rst2;
        end_of_test;
    end
endmodule : tb_top
